// ===== inc/idm_consts.vh
// Constants for the ideal-diode control block
// Assumes inclusion by bare name from hdl files
`ifndef IDM_CONSTS_VH
`define IDM_CONSTS_VH
// State codes shared by both machines
`define IDM_ST_OFF_WAIT 3'h1
`define IDM_ST_WATCH_NEG 3'h2
`define IDM_ST_ASSIST_ON 3'h3
`define IDM_ST_LOCKED 3'h4
`define IDM_ST_CMD_ON 3'h5
// Falling-edge blanking time in ns, and cycle period in ns
`define IDM_BLANK_NS 200
`define IDM_CLK_NS 4
// Blanking cycles, rounded down, at least one
`define IDM_BLANK_CYC ((`IDM_BLANK_NS / `IDM_CLK_NS) < 1 ? 1 : (`IDM_BLANK_NS / `IDM_CLK_NS))
`define IDM_BLANK_W 8
`endif

// ===== hdl/idm_sync2.v
// Two-flop synchroniser for one asynchronous level
// Assumes destination clock clk_sys and synced reset
`timescale 1ns/1ps
module idm_sync2 (
    input wire clk_sys,
    input wire rst_n,
    input wire d_async,
    output wire q_sync
);
    reg meta_r;
    reg q_r;
    // First stage feeds only the second
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= 1'b0;
            q_r <= 1'b0;
        end else begin
            meta_r <= d_async;
            q_r <= meta_r;
        end
    end
    assign q_sync = q_r;
endmodule

// ===== hdl/idm_blank_timer.v
// Blanking timer started by a one-cycle pulse
// Assumes start pulse from logic on clk_sys
`timescale 1ns/1ps
`include "idm_consts.vh"
module idm_blank_timer (
    input wire clk_sys,
    input wire rst_n,
    input wire start,
    output wire expired
);
    reg [`IDM_BLANK_W-1:0] cnt_r;
    reg run_r;
    reg done_r;
    // Load value cut to the counter width on purpose
    wire [31:0] load_full = `IDM_BLANK_CYC - 32'h1;
    // Counts blank cycles, restart on each start
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= {`IDM_BLANK_W{1'b0}};
            run_r <= 1'b0;
            done_r <= 1'b0;
        end else if (start) begin
            cnt_r <= load_full[`IDM_BLANK_W-1:0];
            run_r <= 1'b1;
            done_r <= 1'b0;
        end else if (run_r) begin
            if (cnt_r == {`IDM_BLANK_W{1'b0}}) begin
                run_r <= 1'b0;
                done_r <= 1'b1;
            end else begin
                cnt_r <= cnt_r - 1'b1;
            end
        end else begin
            done_r <= 1'b0;
        end
    end
    assign expired = done_r; // R18
endmodule

// ===== hdl/idm_ctrl.v
// Ideal-diode control: operational assist and overheat diode machines
// Assumes async pins and comparator flags; one 250 MHz clock
// Assumes the flags are already filtered against switching noise
// All outputs come from flops on clk_sys
//
// Notes on behaviour
// R01 - Command fall: off, wait positive drain
// R02 - State 2: off, negative drain goes 3
// R03 - Assist starts in state 2 after reset/overheat
// R04 - State 3: on, forward current goes 4
// R05 - State 4 locked off until command high
// R06 - Command high forces state 5, on
// R07 - One assist turn-on per command cycle
// R08 - Overheat: command fall forces 1, timer
// R09 - Overheat: blank expiry moves 1 to 2
// R10 - Overheat state 2 off, negative drain 3
// R11 - Overheat machine starts in state 2
// R12 - Overheat state 3 on, forward current 2
// R13 - No command: overheat cycles 2 and 3
// R14 - Overheat machine has no shoot-through lockout
// R15 - Controller toggles overheated device first
// R16 - Alarm while either sensor hot
// R17 - Synced flags; overheat selects machine
// R18 - Blanking is a counted cycle interval
`timescale 1ns/1ps
`include "idm_consts.vh"
module idm_ctrl (
    input wire clk_sys,
    input wire rst_n,
    input wire cmd_in,
    input wire drain_pos,
    input wire drain_neg,
    input wire cur_fwd,
    input wire fet_hot,
    input wire drv_hot,
    output wire fet_on,
    output wire alarm_n,
    output wire overheat_shutdown,
    output wire [2:0] assist_state,
    output wire [2:0] diode_state
);
    // Reset release chain
    reg rst_m_r;
    reg rst_s_r;
    wire rst_sn;

    // Synchronised pin levels
    wire cmd_s;
    wire pos_s;
    wire neg_s;
    wire fwd_s;
    wire fhot_s;
    wire dhot_s;

    // Edge history and one-cycle strobes
    reg cmd_d_r;
    reg ot_d_r;
    wire cmd_fall;
    wire ot_now;
    wire ot_exit;
    wire ot_enter;
    wire blank_done;

    // Machine state and registered outputs
    reg [2:0] op_r;
    reg [2:0] op_nxt;
    reg [2:0] ot_r;
    reg [2:0] ot_nxt;
    reg fet_nxt;
    reg fet_r;
    reg alarm_r;
    reg ot_out_r;

    // State codes, shared by both machines
    localparam [2:0] ST_OFF_WAIT = `IDM_ST_OFF_WAIT;
    localparam [2:0] ST_WATCH_NEG = `IDM_ST_WATCH_NEG;
    localparam [2:0] ST_ASSIST_ON = `IDM_ST_ASSIST_ON;
    localparam [2:0] ST_LOCKED = `IDM_ST_LOCKED;
    localparam [2:0] ST_CMD_ON = `IDM_ST_CMD_ON;

    // Reset release through two flops
    // Logic below leaves reset two edges after rst_n rises
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rst_m_r <= 1'b0;
            rst_s_r <= 1'b0;
        end else begin
            rst_m_r <= 1'b1;
            rst_s_r <= rst_m_r;
        end
    end
    assign rst_sn = rst_s_r;

    // Synchronise all asynchronous inputs
    // Every pin and comparator flag passes two flops first
    // Switching command from the controller
    idm_sync2 u_s_cmd (
        .clk_sys(clk_sys),
        .rst_n(rst_sn),
        .d_async(cmd_in),
        .q_sync(cmd_s)
    );

    // Drain voltage positive
    idm_sync2 u_s_pos (
        .clk_sys(clk_sys),
        .rst_n(rst_sn),
        .d_async(drain_pos),
        .q_sync(pos_s)
    );

    // Drain voltage negative
    idm_sync2 u_s_neg (
        .clk_sys(clk_sys),
        .rst_n(rst_sn),
        .d_async(drain_neg),
        .q_sync(neg_s)
    );

    // First-quadrant drain current
    idm_sync2 u_s_fwd (
        .clk_sys(clk_sys),
        .rst_n(rst_sn),
        .d_async(cur_fwd),
        .q_sync(fwd_s)
    );

    // Transistor overheat sensor
    idm_sync2 u_s_fh (
        .clk_sys(clk_sys),
        .rst_n(rst_sn),
        .d_async(fet_hot),
        .q_sync(fhot_s)
    );

    // Driver overheat sensor
    idm_sync2 u_s_dh (
        .clk_sys(clk_sys),
        .rst_n(rst_sn),
        .d_async(drv_hot),
        .q_sync(dhot_s)
    );

    // Either sensor hot keeps overheat mode
    // Normal operation only once both are cool
    assign ot_now = fhot_s | dhot_s; // R16

    // Edge detection on synced copies
    // History resets to idle levels, so no false edge
    always @(posedge clk_sys or negedge rst_sn) begin
        if (!rst_sn) begin
            cmd_d_r <= 1'b0;
            ot_d_r <= 1'b0;
        end else begin
            cmd_d_r <= cmd_s;
            ot_d_r <= ot_now;
        end
    end
    // Command fall restarts blanking and the overheat diode cycle
    assign cmd_fall = cmd_d_r & ~cmd_s;
    // Overheat leave and entry, one cycle each
    assign ot_exit = ot_d_r & ~ot_now;
    assign ot_enter = ~ot_d_r & ot_now;

    // Blanking timer started on every command fall
    // It runs in both modes; only the overheat machine reads it
    idm_blank_timer u_blank (
        .clk_sys(clk_sys),
        .rst_n(rst_sn),
        .start(cmd_fall), // R08
        .expired(blank_done)
    );

    // Operational assist next state
    always @* begin
        op_nxt = op_r;
        if (ot_now || ot_exit) begin
            // Held at watch while hot, resumes there on exit
            op_nxt = ST_WATCH_NEG; // R03
        end else if (cmd_s) begin
            op_nxt = ST_CMD_ON; // R06
        end else begin
            case (op_r)
                ST_CMD_ON: begin
                    // Command gone: off until drain swings positive
                    op_nxt = ST_OFF_WAIT; // R01
                end
                ST_OFF_WAIT: begin
                    // Negative drain ignored until it has been positive
                    if (pos_s) begin
                        op_nxt = ST_WATCH_NEG; // R01
                    end
                end
                ST_WATCH_NEG: begin
                    // Negative drain after positive marks the soft edge
                    if (neg_s) begin
                        op_nxt = ST_ASSIST_ON; // R02
                    end
                end
                ST_ASSIST_ON: begin
                    // Forward current means shoot-through: lock off
                    if (fwd_s) begin
                        op_nxt = ST_LOCKED; // R04
                    end
                end
                ST_LOCKED: begin
                    // Only a command high or overheat leaves the lockout
                    op_nxt = ST_LOCKED; // R05 R07
                end
                default: begin
                    // Illegal code recovers to watch, gate off
                    op_nxt = ST_WATCH_NEG;
                end
            endcase
        end
    end

    // Overheat diode next state
    always @* begin
        ot_nxt = ot_r;
        if (!ot_now) begin
            // Parked at watch so entry starts there
            ot_nxt = ST_WATCH_NEG; // R11
        end else if (ot_enter) begin
            // First hot cycle is spent in watch, gate off
            ot_nxt = ST_WATCH_NEG; // R11
        end else if (cmd_fall) begin
            ot_nxt = ST_OFF_WAIT; // R08
        end else begin
            case (ot_r)
                ST_OFF_WAIT: begin
                    // Fixed wait, no positive drain needed
                    if (blank_done) begin
                        ot_nxt = ST_WATCH_NEG; // R09
                    end
                end
                ST_WATCH_NEG: begin
                    // No lockout: every negative drain turns on again
                    if (neg_s) begin
                        ot_nxt = ST_ASSIST_ON; // R10 R13 R14
                    end
                end
                ST_ASSIST_ON: begin
                    // Forward current turns the gate off again
                    if (fwd_s) begin
                        ot_nxt = ST_WATCH_NEG; // R12 R13
                    end
                end
                default: begin
                    // Illegal code recovers to watch, gate off
                    ot_nxt = ST_WATCH_NEG;
                end
            endcase
        end
    end

    // Gate decode: overheat status picks the machine
    always @* begin
        if (ot_now) begin
            // Diode machine drives the gate in state 3 only
            fet_nxt = (ot_nxt == ST_ASSIST_ON); // R17 R10
        end else begin
            // Assist machine drives the gate in states 3 and 5
            fet_nxt = (op_nxt == ST_CMD_ON) || (op_nxt == ST_ASSIST_ON); // R17 R04
        end
    end

    // State registers; both machines leave reset at watch
    // The state codes are exported for observation
    always @(posedge clk_sys or negedge rst_sn) begin
        if (!rst_sn) begin
            op_r <= ST_WATCH_NEG; // R03
            ot_r <= ST_WATCH_NEG; // R11
        end else begin
            op_r <= op_nxt;
            ot_r <= ot_nxt;
        end
    end

    // Gate drive from a flop, so no decode glitch reaches the pin
    always @(posedge clk_sys or negedge rst_sn) begin
        if (!rst_sn) begin
            fet_r <= 1'b0;
        end else begin
            fet_r <= fet_nxt;
        end
    end

    // Alarm and overheat status; both follow either sensor
    always @(posedge clk_sys or negedge rst_sn) begin
        if (!rst_sn) begin
            alarm_r <= 1'b0;
            ot_out_r <= 1'b0;
        end else begin
            alarm_r <= ot_now; // R16
            ot_out_r <= ot_now; // R16
        end
    end

    // Outputs straight from flops
    assign fet_on = fet_r;
    assign alarm_n = ~alarm_r;
    assign overheat_shutdown = ot_out_r;
    assign assist_state = op_r;
    assign diode_state = ot_r;
endmodule

// ===== sim/idm_ctrl_chk.sv
// Checker for the ideal-diode control block, on its ports
// Assumes pins change off the rising edge
`timescale 1ns/1ps
module idm_ctrl_chk (
    input wire clk_sys,
    input wire rst_n,
    input wire cmd_in,
    input wire drain_pos,
    input wire drain_neg,
    input wire cur_fwd,
    input wire fet_hot,
    input wire drv_hot,
    input wire fet_on,
    input wire alarm_n,
    input wire overheat_shutdown,
    input wire [2:0] assist_state,
    input wire [2:0] diode_state
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // Both sensors cold at the pins
    wire cool = !fet_hot && !drv_hot;
    wire hot_pin = fet_hot || drv_hot;
    cmd_on_a: assert property ((cmd_in && !overheat_shutdown)[*6] |-> assist_state == 3'h5 && fet_on)
        else $error("assist not on under command");
    assist_off_a: assert property ((!overheat_shutdown && assist_state inside {3'h1, 3'h2, 3'h4})[*2] |-> !fet_on)
        else $error("transistor on in an off state");
    assist_on_a: assert property ((!overheat_shutdown && assist_state == 3'h3)[*2] |-> fet_on)
        else $error("transistor off in assist state");
    wait_pos_a: assert property ((cool && assist_state == 3'h1 && !drain_pos)[*4] |=> assist_state != 3'h2)
        else $error("left state 1 without positive drain");
    lock_hold_a: assert property ((cool && assist_state == 3'h4 && !cmd_in)[*4] |=> assist_state == 3'h4)
        else $error("lockout left without command");
    alarm_on_a: assert property ((fet_hot || drv_hot)[*6] |-> overheat_shutdown && !alarm_n)
        else $error("alarm missing while hot");
    entry_two_a: assert property ($rose(overheat_shutdown) |-> diode_state == 3'h2)
        else $error("overheat machine not entered at 2");
    blank_end_a: assert property ($rose(diode_state == 3'h1) |-> ##[45:57] diode_state == 3'h2)
        else $error("blanking did not end in time");
    diode_fwd_a: assert property ((cur_fwd && overheat_shutdown)[*4] |-> diode_state != 3'h3)
        else $error("diode stays on with forward current");
    diode_on_a: assert property ((overheat_shutdown && diode_state == 3'h3)[*2] |-> fet_on)
        else $error("diode state 3 without gate drive");
    alarm_off_a: assert property (cool[*6] |-> !overheat_shutdown && alarm_n)
        else $error("alarm stays after both sensors cool");
    ot_fall_a: assert property ($fell(cmd_in) && hot_pin && $past(hot_pin)
        && overheat_shutdown |-> ##3 diode_state == 3'h1 && !fet_on)
        else $error("command fall in overheat did not force state 1");
endmodule
bind idm_ctrl idm_ctrl_chk chk (.clk_sys(clk_sys), .rst_n(rst_n), .cmd_in(cmd_in),
    .drain_pos(drain_pos), .drain_neg(drain_neg), .cur_fwd(cur_fwd), .fet_hot(fet_hot),
    .drv_hot(drv_hot), .fet_on(fet_on), .alarm_n(alarm_n),
    .overheat_shutdown(overheat_shutdown), .assist_state(assist_state),
    .diode_state(diode_state));

// ===== sim/idm_cmd_src.sv
// Controller model that drives the switching command
// Assumes the bench requests a level on cmd_want
`timescale 1ns/1ps
module idm_cmd_src (
    input wire clk_sys,
    input wire cmd_want,
    output logic cmd_in
);
    logic pend_r = 1'b0;
    initial cmd_in = 1'b0;
    // Take the request on the rising edge, drive on the falling one
    always @(posedge clk_sys) begin
        pend_r <= cmd_want;
    end
    always @(negedge clk_sys) begin
        cmd_in <= pend_r;
    end
endmodule

// ===== sim/idm_tb.sv
// Testbench for the ideal-diode control block
// Assumes a 4 ns clock and the command model
`timescale 1ns/1ps
module testbench;
    logic clk_sys = 0;
    logic rst_n = 0;
    logic cmd_want = 0;
    logic drain_pos = 0;
    logic drain_neg = 0;
    logic cur_fwd = 0;
    logic fet_hot = 0;
    logic drv_hot = 0;
    wire cmd_in, fet_on, alarm_n, overheat_shutdown;
    wire [2:0] assist_state, diode_state;
    int miscompares = 0;
    int num_checks = 0;
    always #2 clk_sys = ~clk_sys;
    idm_cmd_src src (.clk_sys(clk_sys), .cmd_want(cmd_want), .cmd_in(cmd_in));
    idm_ctrl dut (.clk_sys(clk_sys), .rst_n(rst_n), .cmd_in(cmd_in), .drain_pos(drain_pos),
        .drain_neg(drain_neg), .cur_fwd(cur_fwd), .fet_hot(fet_hot), .drv_hot(drv_hot),
        .fet_on(fet_on), .alarm_n(alarm_n), .overheat_shutdown(overheat_shutdown),
        .assist_state(assist_state), .diode_state(diode_state));
    // Compare one packed value
    task automatic chk(input logic [3:0] got, input logic [3:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Set all pins at the falling edge, wait, compare state and gate
    task automatic step(input logic [5:0] v, input bit dio, input logic [3:0] e, input int n);
        {cmd_want, drain_pos, drain_neg, cur_fwd, fet_hot, drv_hot} = v;
        repeat (n) @(negedge clk_sys);
        chk(dio ? {diode_state, fet_on} : {assist_state, fet_on}, e);
    endtask
    task automatic t_reset;
        step(6'h00, 0, 4'h4, 4);
        step(6'h00, 1, 4'h4, 0);
        chk({2'h0, overheat_shutdown, alarm_n}, 4'h1);
        $display("test reset done");
    endtask
    task automatic t_assist;
        step(6'h20, 0, 4'hB, 6);
        step(6'h08, 0, 4'h2, 6);
        step(6'h10, 0, 4'h4, 6);
        step(6'h08, 0, 4'h7, 6);
        step(6'h0C, 0, 4'h8, 6);
        step(6'h10, 0, 4'h8, 6);
        step(6'h08, 0, 4'h8, 6);
        step(6'h20, 0, 4'hB, 6);
        step(6'h00, 0, 4'h2, 6);
        $display("test assist done");
    endtask
    task automatic t_overheat;
        step(6'h02, 1, 4'h4, 6);
        chk({2'h0, overheat_shutdown, alarm_n}, 4'h2);
        step(6'h0A, 1, 4'h7, 6);
        step(6'h06, 1, 4'h4, 6);
        step(6'h0A, 1, 4'h7, 6);
        step(6'h02, 1, 4'h7, 6);
        step(6'h22, 1, 4'h7, 6);
        step(6'h0A, 1, 4'h2, 6);
        step(6'h0A, 1, 4'h2, 38);
        step(6'h02, 1, 4'h4, 20);
        step(6'h01, 1, 4'h4, 6);
        chk({2'h0, overheat_shutdown, alarm_n}, 4'h2);
        step(6'h00, 0, 4'h4, 6);
        chk({2'h0, overheat_shutdown, alarm_n}, 4'h1);
        $display("test overheat done");
    endtask
    task automatic conclude;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Hold reset three cycles, then run each scenario
    initial begin
        repeat (3) @(negedge clk_sys);
        rst_n = 1;
        t_reset();
        t_assist();
        t_overheat();
        conclude();
    end
endmodule
